// [motion_feature_pkg.sv]
// Constants, register map and carrier types for the motion feature engine.
// Assumes a single 25 MHz clock and an Avalon-MM slave with 32-bit data.
// Summary of operation
// - Step alert interval field counts in units of twenty steps, up to 20460.
// - Step alert raised each time the interval count of steps accumulates.
// - Interval field zero disables interval alert; per-step alert used instead.
// - Step total clear honoured only while pedometer is on.
// - Separate enables for pedometer accumulation and per-step detection.
// - Gait classed as walking, running or still when classification and pedometer enabled.
// - Gait change sets an event flag; current class readable separately.
// - Wrist tilt detected on the remapped y axis; host chooses its source axis.
// - Axis selector 0 x, 1 y, 2 z; sign bit 1 negates.
// - Enable bit switches wrist tilt detection.
// - Tap detected on z only when tap enable set.
// - Double tap by default; single-knock flag selects single tap.
// - Tap sensitivity 0 most sensitive to 7 least.
// - Slope engine runs only with at least one axis enabled.
// - Any-motion asserts when slope exceeds threshold for duration points.
// - Slope is sample minus reference; reference updated during any-motion.
// - Any-motion deasserts after duration points below threshold.
// - Stillness select turns slope engine into a no-motion detector.
// - No-motion asserts when all selected axes below threshold for duration.
// - Step total is 32 bits in four byte-wide registers.
// - Clear flag self-clears and accumulation restarts from zero.
// - Stillness select 1 means no-motion, 0 means any-motion.
// - Feature events latched until the status register is read.
package motion_feature_pkg;
  localparam logic [5:0] OFS_STEP_CFG = 6'h00;
  localparam logic [5:0] OFS_REMAP = 6'h04;
  localparam logic [5:0] OFS_TILT_TAP = 6'h08;
  localparam logic [5:0] OFS_SLOPE_CFG = 6'h0c;
  localparam logic [5:0] OFS_EVT_STATUS = 6'h10;
  localparam logic [5:0] OFS_GAIT = 6'h14;
  localparam logic [5:0] OFS_STEP_0 = 6'h18;
  localparam logic [5:0] OFS_STEP_1 = 6'h1c;
  localparam logic [5:0] OFS_STEP_2 = 6'h20;
  localparam logic [5:0] OFS_STEP_3 = 6'h24;
  // Step config field positions
  localparam int SC_INTERVAL_LSB = 0;
  localparam int SC_CLEAR_BIT = 10;
  localparam int SC_EN_COUNT_BIT = 12;
  localparam int SC_EN_DETECT_BIT = 13;
  localparam int SC_EN_GAIT_BIT = 14;
  // Tilt/tap field positions
  localparam int TT_TILT_EN_BIT = 0;
  localparam int TT_TAP_EN_BIT = 1;
  localparam int TT_SINGLE_BIT = 2;
  localparam int TT_SENS_LSB = 3;
  // Slope config field positions
  localparam int SL_THR_LSB = 0;
  localparam int SL_STILL_BIT = 11;
  localparam int SL_DUR_LSB = 16;
  localparam int SL_EN_LSB = 29;
  // Event status bit positions
  localparam int EV_STEP = 0;
  localparam int EV_GAIT = 1;
  localparam int EV_TILT = 3;
  localparam int EV_TAP = 4;
  localparam int EV_SLOPE = 5;
  localparam logic [10:0] STEP_UNIT = 11'd20;
  localparam logic [31:0] RST_STEP_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_REMAP = 32'h0000_0088;
  localparam logic [31:0] RST_TILT_TAP = 32'h0000_0000;
  localparam logic [31:0] RST_SLOPE_CFG = 32'h0000_00aa;
  localparam logic [11:0] TILT_LEVEL = 12'h200;
  localparam logic [11:0] TAP_BASE = 12'h100;
  localparam logic [11:0] TAP_STEP = 12'h080;
  localparam logic [11:0] WALK_LEVEL = 12'h100;
  localparam logic [11:0] RUN_LEVEL = 12'h400;
  localparam logic [5:0] TAP_WINDOW = 6'h19;
  localparam logic [6:0] GAIT_IDLE = 7'h64;

  typedef enum logic [1:0] {
    GAIT_STILL = 2'b00,
    GAIT_WALK = 2'b01,
    GAIT_RUN = 2'b10
  } gait_e;

  typedef enum logic [1:0] {
    TAP_IDLE = 2'b00,
    TAP_HIGH = 2'b01,
    TAP_WAIT = 2'b10
  } tap_e;

  typedef struct packed {
    logic signed [11:0] x;
    logic signed [11:0] y;
    logic signed [11:0] z;
  } accel_s;

  typedef struct packed {
    logic neg;
    logic [1:0] src;
  } axis_map_s;
endpackage

// [motion_feature_engine.sv]
// Motion feature engine: pedometer, gait, tilt, tap and slope detection.
// Assumes acceleration samples arrive with a one-cycle sample_valid pulse.
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module motion_feature_engine
  import motion_feature_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sample_valid,
  input wire accel_s sample,
  input wire logic step_pulse,
  output logic event_any_ff
);
  logic [31:0] step_cfg_ff;
  logic [31:0] remap_ff;
  logic [31:0] tilt_tap_ff;
  logic [31:0] slope_cfg_ff;
  logic [31:0] step_total_ff;
  logic [31:0] next_alert_ff;
  logic [5:0] events_ff;
  gait_e gait_ff;
  logic [6:0] gait_idle_ff;
  logic [11:0] peak_ff;
  logic tilt_seen_ff;
  tap_e tap_ff;
  logic [5:0] tap_cnt_ff;
  accel_s ref_ff;
  logic motion_ff;
  logic still_q_ff;
  logic [7:0] dur_cnt_ff;
  logic [31:0] avs_readdata_ff;
  logic ack_ff;
  logic wait_ff;
  logic [5:0] evt_set;
  logic wr_hit;
  logic rd_hit;

  assign avs_readdata = avs_readdata_ff;
  assign avs_waitrequest = wait_ff;
  assign wr_hit = avs_write & ack_ff;
  assign rd_hit = avs_read & ack_ff;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic signed [11:0] pick(input accel_s s,
      input axis_map_s m);
    logic signed [11:0] v;
    v = (m.src == 2'd0) ? s.x : (m.src == 2'd1) ? s.y : s.z;
    return m.neg ? -v : v;
  endfunction

  function automatic logic [11:0] mag(input logic signed [11:0] v);
    return v[11] ? 12'(-v) : 12'(v);
  endfunction

  function automatic logic is_status(input logic [5:0] a);
    return a == OFS_EVT_STATUS;
  endfunction

  // Remapped axes
  accel_s rm;
  assign rm.x = pick(sample, axis_map_s'(remap_ff[2:0]));
  assign rm.y = pick(sample, axis_map_s'(remap_ff[5:3]));
  assign rm.z = pick(sample, axis_map_s'(remap_ff[8:6]));

  wire en_count = step_cfg_ff[SC_EN_COUNT_BIT];
  wire en_detect = step_cfg_ff[SC_EN_DETECT_BIT];
  wire en_gait = step_cfg_ff[SC_EN_GAIT_BIT];
  wire [9:0] interval = step_cfg_ff[SC_INTERVAL_LSB +: 10];
  wire [31:0] interval_steps = 32'(interval) * 32'(STEP_UNIT);
  wire clear_req = step_cfg_ff[SC_CLEAR_BIT] & en_count;

  // Bus handshake: one wait cycle, then acknowledge
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
      wait_ff <= ~((avs_read | avs_write) & ~ack_ff);
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      step_cfg_ff <= RST_STEP_CFG;
      remap_ff <= RST_REMAP;
      tilt_tap_ff <= RST_TILT_TAP;
      slope_cfg_ff <= RST_SLOPE_CFG;
    end else begin
      if (clear_req) begin
        step_cfg_ff[SC_CLEAR_BIT] <= 1'b0;
      end
      if (wr_hit) begin
        if (avs_address == OFS_STEP_CFG) begin
          step_cfg_ff <= merge(step_cfg_ff, avs_writedata, avs_byteenable);
        end else if (avs_address == OFS_REMAP) begin
          remap_ff <= merge(remap_ff, avs_writedata, avs_byteenable);
        end else if (avs_address == OFS_TILT_TAP) begin
          tilt_tap_ff <= merge(tilt_tap_ff, avs_writedata, avs_byteenable);
        end else if (avs_address == OFS_SLOPE_CFG) begin
          slope_cfg_ff <= merge(slope_cfg_ff, avs_writedata, avs_byteenable);
        end
      end
    end
  end

  // Step total and interval alert threshold
  always_ff @(posedge mclk) begin
    if (rst) begin
      step_total_ff <= 32'h0000_0000;
      next_alert_ff <= 32'h0000_0000;
    end else if (clear_req) begin
      step_total_ff <= 32'h0000_0000;
      next_alert_ff <= interval_steps;
    end else if (en_count && step_pulse) begin
      step_total_ff <= step_total_ff + 32'h0000_0001;
      if (interval != 10'h000 &&
          step_total_ff + 32'h0000_0001 >= next_alert_ff) begin
        next_alert_ff <= next_alert_ff + interval_steps;
      end
    end else if (next_alert_ff == 32'h0000_0000 ||
                 next_alert_ff <= step_total_ff) begin
      next_alert_ff <= step_total_ff + interval_steps;
    end
  end

  // Largest vertical swing since the last step
  always_ff @(posedge mclk) begin
    if (rst) begin
      peak_ff <= 12'h000;
    end else if (step_pulse) begin
      peak_ff <= 12'h000;
    end else if (sample_valid && mag(rm.z) > peak_ff) begin
      peak_ff <= mag(rm.z);
    end
  end

  // Gait classification from peak magnitude between steps
  always_ff @(posedge mclk) begin
    if (rst) begin
      gait_ff <= GAIT_STILL;
      gait_idle_ff <= 7'h00;
    end else if (!en_gait || !en_count) begin
      gait_ff <= GAIT_STILL;
      gait_idle_ff <= 7'h00;
    end else if (step_pulse) begin
      gait_idle_ff <= 7'h00;
      if (peak_ff >= RUN_LEVEL) begin
        gait_ff <= GAIT_RUN;
      end else begin
        gait_ff <= GAIT_WALK;
      end
    end else if (sample_valid) begin
      if (gait_idle_ff == GAIT_IDLE) begin
        gait_ff <= GAIT_STILL;
      end else begin
        gait_idle_ff <= gait_idle_ff + 7'h01;
      end
    end
  end

  gait_e gait_q_ff;
  always_ff @(posedge mclk) begin
    if (rst) begin
      gait_q_ff <= GAIT_STILL;
    end else begin
      gait_q_ff <= gait_ff;
    end
  end

  // Wrist tilt on remapped y axis, portrait up
  always_ff @(posedge mclk) begin
    if (rst) begin
      tilt_seen_ff <= 1'b0;
    end else if (!tilt_tap_ff[TT_TILT_EN_BIT]) begin
      tilt_seen_ff <= 1'b0;
    end else if (sample_valid) begin
      tilt_seen_ff <= (rm.y >= $signed(TILT_LEVEL));
    end
  end
  wire tilt_now = sample_valid & tilt_tap_ff[TT_TILT_EN_BIT] &
                  (rm.y >= $signed(TILT_LEVEL)) & ~tilt_seen_ff;

  // Tap detection on z
  wire [11:0] tap_level = TAP_BASE +
      12'(tilt_tap_ff[TT_SENS_LSB +: 3]) * TAP_STEP;
  wire tap_hi = mag(sample.z) >= tap_level;
  logic tap_fire;
  always_ff @(posedge mclk) begin
    if (rst) begin
      tap_ff <= TAP_IDLE;
      tap_cnt_ff <= 6'h00;
    end else if (!tilt_tap_ff[TT_TAP_EN_BIT]) begin
      tap_ff <= TAP_IDLE;
      tap_cnt_ff <= 6'h00;
    end else if (sample_valid) begin
      case (tap_ff)
        TAP_IDLE: begin
          if (tap_hi) begin
            tap_ff <= tilt_tap_ff[TT_SINGLE_BIT] ? TAP_IDLE : TAP_HIGH;
          end
        end
        TAP_HIGH: begin
          tap_cnt_ff <= 6'h00;
          if (!tap_hi) begin
            tap_ff <= TAP_WAIT;
          end
        end
        TAP_WAIT: begin
          tap_cnt_ff <= tap_cnt_ff + 6'h01;
          if (tap_hi || tap_cnt_ff == TAP_WINDOW) begin
            tap_ff <= TAP_IDLE;
          end
        end
        default: tap_ff <= TAP_IDLE;
      endcase
    end
  end
  always_comb begin
    tap_fire = 1'b0;
    if (tilt_tap_ff[TT_TAP_EN_BIT] && sample_valid) begin
      if (tap_ff == TAP_IDLE && tap_hi && tilt_tap_ff[TT_SINGLE_BIT]) begin
        tap_fire = 1'b1;
      end else if (tap_ff == TAP_WAIT && tap_hi) begin
        tap_fire = 1'b1;
      end
    end
  end

  // Slope engine
  wire [10:0] thr = slope_cfg_ff[SL_THR_LSB +: 11];
  wire [7:0] dur = slope_cfg_ff[SL_DUR_LSB +: 8];
  wire [2:0] axis_en = slope_cfg_ff[SL_EN_LSB +: 3];
  wire still_sel = slope_cfg_ff[SL_STILL_BIT];
  logic [2:0] over;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_slope
      logic signed [12:0] d;
      logic [12:0] a;
      assign d = 13'(signed'(rm[(2 - g) * 12 +: 12])) -
                 13'(signed'(ref_ff[(2 - g) * 12 +: 12]));
      assign a = d[12] ? 13'(-d) : d;
      assign over[g] = axis_en[g] & (a > 13'(thr));
    end
  endgenerate
  wire any_over = |over;
  wire all_under = ~any_over;
  wire slope_on = |axis_en;
  wire cond = still_sel ? all_under : (motion_ff ? all_under : any_over);

  // Mode seen last cycle; a mode change restarts detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      still_q_ff <= RST_SLOPE_CFG[SL_STILL_BIT];
    end else begin
      still_q_ff <= still_sel;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_ff <= '0;
      motion_ff <= 1'b0;
      dur_cnt_ff <= 8'h00;
    end else if (!slope_on) begin
      motion_ff <= 1'b0;
      dur_cnt_ff <= 8'h00;
    end else if (still_sel != still_q_ff) begin
      motion_ff <= 1'b0;
      dur_cnt_ff <= 8'h00;
    end else if (sample_valid) begin
      if (still_sel || motion_ff || !any_over) begin
        ref_ff <= rm;
      end
      if (!cond) begin
        dur_cnt_ff <= 8'h00;
        if (still_sel) begin
          motion_ff <= 1'b0;
        end
      end else if (dur_cnt_ff + 8'h01 >= dur) begin
        dur_cnt_ff <= 8'h00;
        motion_ff <= still_sel ? 1'b1 : ~motion_ff;
      end else begin
        dur_cnt_ff <= dur_cnt_ff + 8'h01;
      end
    end
  end
  wire slope_evt = sample_valid & slope_on & cond & ~motion_ff &
                   (still_sel == still_q_ff) &
                   (dur_cnt_ff + 8'h01 >= dur);

  // Latched event flags
  always_comb begin
    evt_set = 6'h00;
    evt_set[EV_STEP] = en_count & step_pulse & (interval != 10'h000) &
                       (step_total_ff + 32'h0000_0001 >= next_alert_ff);
    if (interval == 10'h000) begin
      evt_set[EV_STEP] = en_detect & step_pulse;
    end
    evt_set[EV_GAIT] = gait_ff != gait_q_ff;
    evt_set[EV_TILT] = tilt_now;
    evt_set[EV_TAP] = tap_fire;
    evt_set[EV_SLOPE] = slope_evt;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      events_ff <= 6'h00;
    end else if (rd_hit && is_status(avs_address)) begin
      events_ff <= evt_set;
    end else begin
      events_ff <= events_ff | evt_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      event_any_ff <= 1'b0;
    end else begin
      event_any_ff <= |events_ff;
    end
  end

  // Read data
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_readdata_ff <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      if (avs_address == OFS_STEP_CFG) begin
        avs_readdata_ff <= step_cfg_ff;
      end else if (avs_address == OFS_REMAP) begin
        avs_readdata_ff <= remap_ff;
      end else if (avs_address == OFS_TILT_TAP) begin
        avs_readdata_ff <= tilt_tap_ff;
      end else if (avs_address == OFS_SLOPE_CFG) begin
        avs_readdata_ff <= slope_cfg_ff;
      end else if (is_status(avs_address)) begin
        avs_readdata_ff <= {26'h0, events_ff | evt_set};
      end else if (avs_address == OFS_GAIT) begin
        avs_readdata_ff <= {30'h0, gait_ff};
      end else if (avs_address == OFS_STEP_0) begin
        avs_readdata_ff <= {24'h0, step_total_ff[7:0]};
      end else if (avs_address == OFS_STEP_1) begin
        avs_readdata_ff <= {24'h0, step_total_ff[15:8]};
      end else if (avs_address == OFS_STEP_2) begin
        avs_readdata_ff <= {24'h0, step_total_ff[23:16]};
      end else if (avs_address == OFS_STEP_3) begin
        avs_readdata_ff <= {24'h0, step_total_ff[31:24]};
      end else begin
        avs_readdata_ff <= 32'h0000_0000;
      end
    end
  end
endmodule

// [motion_feature_engine_sva.sv]
// Checker for the engine's bus handshake, read data and event latch.
// Assumes it is bound to motion_feature_engine and sees only its ports.
`timescale 1ns/1ps
module motion_feature_engine_sva
  import motion_feature_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sample_valid,
  input wire logic step_pulse,
  input wire logic event_any_ff
);
  logic [2:0] quiet_ff;
  logic status_rd;
  assign status_rd = avs_read && avs_address == OFS_EVT_STATUS;
  // Cycles since the last step or sample
  always_ff @(posedge mclk) begin
    if (rst || sample_valid || step_pulse) begin
      quiet_ff <= 3'h0;
    end else if (quiet_ff != 3'h7) begin
      quiet_ff <= quiet_ff + 3'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_req_ack: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not acknowledged after one cycle");
  a_ack_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge longer than one cycle");
  a_idle_wait: assert property (
    !(avs_read || avs_write) |=> avs_waitrequest)
    else $error("acknowledge without request");
  a_rdata_hold: assert property (
    $changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (
    avs_read && avs_waitrequest && avs_address > OFS_STEP_3
    |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_event_latched: assert property (
    event_any_ff && !status_rd && !$past(status_rd) |=> event_any_ff)
    else $error("event dropped without status read");
  a_clear_read: assert property (
    status_rd && !avs_waitrequest && quiet_ff >= 3'h4 && !sample_valid
    && !step_pulse |-> ##2 !event_any_ff)
    else $error("status read did not clear events");
  a_reset_quiet: assert property (
    $fell(rst) |-> avs_waitrequest && !event_any_ff
    && avs_readdata == 32'h0)
    else $error("outputs not idle after reset");
  c_read_ack: cover property (avs_read && !avs_waitrequest);
  c_event: cover property ($rose(event_any_ff));
  c_clear: cover property (status_rd && !avs_waitrequest ##2 !event_any_ff);
endmodule
bind motion_feature_engine motion_feature_engine_sva chk_u (
  .mclk(mclk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sample_valid(sample_valid), .step_pulse(step_pulse),
  .event_any_ff(event_any_ff));

// [motion_source_model.sv]
// Model of the sensor front end that feeds steps and acceleration samples.
// Assumes the bench calls its tasks from one process synchronous to mclk.
`timescale 1ns/1ps
module motion_source_model
  import motion_feature_pkg::*;
(
  input wire logic mclk,
  output logic sample_valid,
  output accel_s sample,
  output logic step_pulse
);
  initial begin
    sample_valid = 1'b0;
    sample = '0;
    step_pulse = 1'b0;
  end
  // One-cycle step pulses, gap + 1 idle cycles apart
  task automatic steps(input int n, input int gap);
    repeat (n) begin
      @(posedge mclk);
      step_pulse <= 1'b1;
      @(posedge mclk);
      step_pulse <= 1'b0;
      repeat (gap) @(posedge mclk);
    end
  endtask
  // Bus shows inverted data outside the valid pulse
  task automatic put(input logic [11:0] x, input logic [11:0] y,
                     input logic [11:0] z);
    @(posedge mclk);
    sample_valid <= 1'b1;
    sample <= {x, y, z};
    @(posedge mclk);
    sample_valid <= 1'b0;
    sample <= ~{x, y, z};
    repeat (3) @(posedge mclk);
  endtask
endmodule

// [motion_feature_engine_tb_top.sv]
// Self-checking bench for the motion feature engine over Avalon-MM.
// Assumes motion_source_model feeds steps and samples.
`timescale 1ns/1ps
module motion_feature_engine_tb_top;
  import motion_feature_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sample_valid;
  accel_s sample;
  logic step_pulse;
  logic event_any_ff;
  logic [31:0] d;
  logic [31:0] tot = 32'd40;
  int fails = 0;
  int tests_run = 0;
  always #20 mclk = ~mclk;
  motion_feature_engine dut_u (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
    .sample(sample), .step_pulse(step_pulse),
    .event_any_ff(event_any_ff));
  motion_source_model src_u (.mclk(mclk), .sample_valid(sample_valid),
    .sample(sample), .step_pulse(step_pulse));
  task automatic report_and_stop;
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus access; read data lands in d
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      report_and_stop();
    end
  endtask
  // Reads and clears the status, checks one flag
  task automatic ev(input int b, input logic e);
    acc(1'b0, OFS_EVT_STATUS, 32'h0);
    chk(32'(d[b]), 32'(e));
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    acc(1'b0, OFS_REMAP, 32'h0);
    chk(d, RST_REMAP);
    acc(1'b0, OFS_SLOPE_CFG, 32'h0);
    chk(d, RST_SLOPE_CFG);
    acc(1'b0, 6'h28, 32'h0);
    chk(d, 32'h0);
    acc(1'b0, OFS_GAIT, 32'h0);
    chk(d, 32'(GAIT_STILL));
    // Interval of one unit: alert at 20 and 40 steps
    acc(1'b1, OFS_STEP_CFG, 32'h0000_1001);
    src_u.steps(19, 1);
    ev(EV_STEP, 1'b0);
    src_u.steps(1, 1);
    ev(EV_STEP, 1'b1);
    src_u.steps(20, 1);
    ev(EV_STEP, 1'b1);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, OFS_STEP_0 + 6'(4 * i), 32'h0);
      chk(32'(d[7:0]), 32'(tot[8 * i +: 8]));
    end
    acc(1'b1, OFS_STEP_CFG, 32'h0000_1401);
    acc(1'b0, OFS_STEP_0, 32'h0);
    chk(d, 32'h0);
    acc(1'b0, OFS_STEP_CFG, 32'h0);
    chk(32'(d[SC_CLEAR_BIT]), 32'h0);
    src_u.steps(3, 1);
    acc(1'b1, OFS_STEP_CFG, 32'h0000_0401);
    acc(1'b0, OFS_STEP_0, 32'h0);
    chk(d, 32'h3);
    // Interval zero: per-step alert only with the detector on
    acc(1'b1, OFS_STEP_CFG, 32'h0000_3000);
    ev(EV_STEP, 1'b0);
    src_u.steps(1, 1);
    ev(EV_STEP, 1'b1);
    acc(1'b1, OFS_STEP_CFG, 32'h0000_1000);
    src_u.steps(1, 1);
    ev(EV_STEP, 1'b0);
    // Gait with pedometer on: a strong swing runs, a weak one walks
    acc(1'b1, OFS_STEP_CFG, 32'h0000_5000);
    src_u.put(12'h0, 12'h0, 12'h500);
    src_u.steps(1, 1);
    ev(EV_GAIT, 1'b1);
    acc(1'b0, OFS_GAIT, 32'h0);
    chk(d, 32'(GAIT_RUN));
    src_u.put(12'h0, 12'h0, 12'h200);
    src_u.steps(1, 1);
    acc(1'b0, OFS_GAIT, 32'h0);
    chk(d, 32'(GAIT_WALK));
    // Tilt on identity map, then all axes taken from x
    acc(1'b1, OFS_TILT_TAP, 32'h1);
    src_u.put(12'h0, 12'h0, 12'h0);
    src_u.put(12'h0, 12'h300, 12'h0);
    chk(32'(event_any_ff), 32'h1);
    ev(EV_TILT, 1'b1);
    acc(1'b1, OFS_REMAP, 32'h0);
    src_u.put(12'h0, 12'h0, 12'h0);
    src_u.put(12'h300, 12'h0, 12'h0);
    ev(EV_TILT, 1'b1);
    acc(1'b1, OFS_REMAP, 32'h0000_0020);
    src_u.put(12'h0, 12'h0, 12'h0);
    src_u.put(12'hd00, 12'h0, 12'h0);
    ev(EV_TILT, 1'b1);
    acc(1'b1, OFS_TILT_TAP, 32'h0);
    src_u.put(12'h0, 12'h0, 12'h0);
    src_u.put(12'hd00, 12'h0, 12'h0);
    ev(EV_TILT, 1'b0);
    // Single tap on z at the lowest and highest sensitivity codes, double tap at the lowest
    acc(1'b1, OFS_REMAP, RST_REMAP);
    acc(1'b1, OFS_TILT_TAP, 32'h6);
    src_u.put(12'h0, 12'h0, 12'h300);
    repeat (30) src_u.put(12'h0, 12'h0, 12'h0);
    ev(EV_TAP, 1'b1);
    acc(1'b1, OFS_TILT_TAP, 32'h2);
    src_u.put(12'h0, 12'h0, 12'h300);
    repeat (30) src_u.put(12'h0, 12'h0, 12'h0);
    ev(EV_TAP, 1'b0);
    src_u.put(12'h0, 12'h0, 12'h300);
    src_u.put(12'h0, 12'h0, 12'h0);
    src_u.put(12'h0, 12'h0, 12'h300);
    ev(EV_TAP, 1'b1);
    acc(1'b1, OFS_TILT_TAP, 32'h3e);
    src_u.put(12'h0, 12'h0, 12'h300);
    repeat (30) src_u.put(12'h0, 12'h0, 12'h0);
    ev(EV_TAP, 1'b0);
    // Slope engine: no axis, x axis, then stillness
    acc(1'b1, OFS_TILT_TAP, 32'h0);
    acc(1'b1, OFS_SLOPE_CFG, 32'h0001_0100);
    src_u.put(12'h0, 12'h0, 12'h0);
    src_u.put(12'h600, 12'h0, 12'h0);
    ev(EV_SLOPE, 1'b0);
    acc(1'b1, OFS_SLOPE_CFG, 32'h2001_0100);
    src_u.put(12'h0, 12'h0, 12'h0);
    src_u.put(12'h600, 12'h0, 12'h0);
    src_u.put(12'h600, 12'h0, 12'h0);
    ev(EV_SLOPE, 1'b1);
    acc(1'b1, OFS_SLOPE_CFG, 32'h2002_0900);
    repeat (6) src_u.put(12'h600, 12'h0, 12'h0);
    ev(EV_SLOPE, 1'b1);
    report_and_stop();
  end
endmodule
